// >>> pkg/edpo_pkg.sv
// Constants, mode type and count checks for the encoder divided pulse output.
// Assumes an 18-bit single-turn position word and a 125 MHz system clock.
// Contract
// R1: Phase A and B are two trains ninety degrees apart.
// R2: Pulse-encoder semi-closed mode forwards encoder pulses, ignoring pulse count setting.
// R3: Serial mode divides encoder counts to programmed pulses; 16 to 1,073,741,824, default 512.
// R4: A new pulse count takes effect only after a restart.
// R5: Index output gives one pulse per mechanical revolution.
// R6: Index pulse width equals phase A pulse width.
// R7: Reverse rotation setting keeps the same output phase form.
// R8: 18-bit encoder: any count to 16,384; x2 to 32,768; x4 to 65,536. Code accepts x2 counts only from 16,836 (BAND_X2_MIN).
// R9: Pulse setting error alarm when count breaks range or increment.
// R10: Speed ceiling per count band: 16,000/12,000/6,000/3,000/1,500 per minute.
// R11: Overspeed alarm when speed exceeds ceiling; output rate capped near 1.6 Mpps.
// R12: Host turns motor two revolutions, or homes at 600 per minute or slower.
// R13: Each phase is a complementary pair, inverted line always opposite.
// R14: Forward rotation: A leads B; reverse rotation: B leads A.
`default_nettype none
package edpo_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          POS_W         = 18;
    localparam int          CNT_W         = 31;
    localparam int          SPD_W         = 16;
    localparam int          CLK_MHZ       = 125;
    localparam logic [19:0] ENC_COUNTS    = 20'h40000;
    localparam logic [30:0] PULSES_RESET  = 31'h00000200;
    localparam logic [30:0] PULSES_MIN    = 31'h00000010;
    localparam logic [30:0] BAND_ANY_MAX  = 31'h00004000;
    localparam logic [30:0] BAND_X2_MIN   = 31'h000041C4;
    localparam logic [30:0] BAND_X2_MAX   = 31'h00008000;
    localparam logic [30:0] BAND_X4_MIN   = 31'h00008004;
    localparam logic [30:0] BAND_X4_MAX   = 31'h00010000;
    localparam logic [30:0] SPD_BAND1_MAX = 31'h00001800;
    localparam logic [30:0] SPD_BAND2_MAX = 31'h00002000;
    localparam logic [15:0] SPD_CEIL1     = 16'h3E80;
    localparam logic [15:0] SPD_CEIL2     = 16'h2EE0;
    localparam logic [15:0] SPD_CEIL3     = 16'h1770;
    localparam logic [15:0] SPD_CEIL4     = 16'h0BB8;
    localparam logic [15:0] SPD_CEIL5     = 16'h05DC;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_PULSES    = 8'h04;
    localparam logic [7:0]  REG_RESTART   = 8'h08;
    localparam logic [7:0]  REG_STATUS    = 8'h0C;
    localparam logic [7:0]  REG_ACTIVE    = 8'h10;
    localparam logic [7:0]  REG_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  REG_IRQ_EN    = 8'h18;
    localparam logic [7:0]  REG_IRQ_CLR   = 8'h1C;
    localparam logic [7:0]  REG_SPD_CEIL  = 8'h20;
    localparam int          CTRL_REV_BIT  = 0;
    localparam int          CTRL_PASS_BIT = 1;
    localparam int          RESTART_BIT   = 0;
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_SETERR    = 0;
    localparam int          IRQ_OVERSPD   = 1;
    localparam int          IRQ_INDEX     = 2;

    typedef enum logic [1:0] {
        MODE_DIVIDE,
        MODE_PASS,
        MODE_FAULT
    } edpo_mode_t;

    function automatic logic edpo_count_ok(input logic [30:0] n);
        logic ok;
        ok = 1'b0;
        if (n >= PULSES_MIN && n <= BAND_ANY_MAX) begin
            ok = 1'b1; // R8
        end else if (n >= BAND_X2_MIN && n <= BAND_X2_MAX) begin
            ok = (n[0] == 1'b0); // R8
        end else if (n >= BAND_X4_MIN && n <= BAND_X4_MAX) begin
            ok = (n[1:0] == 2'b00); // R8
        end
        return ok;
    endfunction

    function automatic logic [15:0] edpo_speed_ceil(input logic [30:0] n);
        logic [15:0] c;
        c = 16'h0000;
        if (n <= SPD_BAND1_MAX) begin
            c = SPD_CEIL1; // R10
        end else if (n <= SPD_BAND2_MAX) begin
            c = SPD_CEIL2;
        end else if (n <= BAND_ANY_MAX) begin
            c = SPD_CEIL3;
        end else if (n <= BAND_X2_MAX) begin
            c = SPD_CEIL4;
        end else if (n <= BAND_X4_MAX) begin
            c = SPD_CEIL5;
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// >>> pkg/edpo_quad_if.sv
// Step and phase signals between the divider control and the quadrature generator.
// Assumes both ends share one clock.
`default_nettype none
interface edpo_quad_if;
    logic step;
    logic fwd;
    logic idxReq;
    logic phA;
    logic phB;
    logic phC;
    modport ctl (output step, fwd, idxReq, input phA, phB, phC);
    modport gen (input step, fwd, idxReq, output phA, phB, phC);
endinterface
`default_nettype wire

// >>> src/edpo_quad_gen.sv
// Quadrature state stepper with index gating on phase A.
// Assumes at most one step per clock, driven from registers of the control side.
`default_nettype none
module edpo_quad_gen (
    input  wire logic  clk,     // System clock
    input  wire logic  reset_n, // Async reset, active low
    edpo_quad_if.gen   q        // Steps in, phases out
);
    import edpo_pkg::*;

    typedef struct packed {
        logic [1:0] ph;
        logic       armed;
        logic       c;
    } edpo_gen_t;

    edpo_gen_t st_r;
    edpo_gen_t st_nxt;
    logic      oldA;
    logic      newA;

    always_comb begin
        st_nxt = st_r;
        oldA   = st_r.ph[0] ^ st_r.ph[1];
        newA   = oldA;
        if (q.idxReq) begin
            st_nxt.armed = 1'b1;
        end
        if (q.step) begin
            // Gray walk 00,10,11,01 for forward keeps A ahead of B
            st_nxt.ph = q.fwd ? st_r.ph + 2'b01 : st_r.ph - 2'b01; // R1 R14
            newA      = st_nxt.ph[0] ^ st_nxt.ph[1];
            if (!oldA && newA && (st_r.armed || q.idxReq)) begin
                st_nxt.c     = 1'b1; // R5 R6
                st_nxt.armed = 1'b0;
            end
            if (oldA && !newA) begin
                st_nxt.c = 1'b0; // R6
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q.phA = st_r.ph[0] ^ st_r.ph[1];
    assign q.phB = st_r.ph[1];
    assign q.phC = st_r.c;

    a_quad_one_edge: assert property (@(posedge clk) disable iff (!reset_n)
        q.step |=> ((q.phA != $past(q.phA)) != (q.phB != $past(q.phB)))) // R1
        else $error("step did not move exactly one phase");
    a_lead_fwd: assert property (@(posedge clk) disable iff (!reset_n)
        (q.step && q.fwd && q.phA == q.phB) |=> (q.phA != $past(q.phA))) // R14
        else $error("forward step did not let A lead");
    a_index_rise: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(q.phC) |-> $rose(q.phA)) // R6
        else $error("index rose without phase A");
    a_index_fall: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(q.phA) |-> !q.phC) // R6
        else $error("index outlived phase A");
    c_index_pulse: cover property (@(posedge clk) disable iff (!reset_n) $rose(q.phC));
endmodule
`default_nettype wire

// >>> src/edpo_divider.sv
// Encoder divided pulse output: register port, divider, pass-through and alarms.
// Assumes synchronous inputs, one position sample moving at most one count.
//
// The placing of the registers and the plain strobed port were decided locally.
`default_nettype none
module edpo_divider (
    input  wire logic                        clk,           // System clock 125 MHz
    input  wire logic                        reset_n,       // Async reset, active low
    input  wire logic [edpo_pkg::ADDR_W-1:0] regAddr,       // Register byte address
    input  wire logic [edpo_pkg::DATA_W-1:0] regWdata,      // Register write data
    input  wire logic                        regWr,         // Write strobe
    input  wire logic                        regRd,         // Read strobe
    output var  logic [edpo_pkg::DATA_W-1:0] regRdata,      // Read data, cycle after strobe
    input  wire logic [edpo_pkg::POS_W-1:0]  encPos,        // Serial encoder position
    input  wire logic                        encValid,      // Position sample strobe
    input  wire logic                        encA,          // Pulse encoder phase A
    input  wire logic                        encB,          // Pulse encoder phase B
    input  wire logic                        encC,          // Pulse encoder index
    input  wire logic [edpo_pkg::SPD_W-1:0]  motorSpeed,    // Speed magnitude per minute
    output var  logic                        quad_out_a,    // Phase A
    output var  logic                        quad_out_a_n,  // Phase A inverted
    output var  logic                        quad_out_b,    // Phase B
    output var  logic                        quad_out_b_n,  // Phase B inverted
    output var  logic                        index_out,     // Phase C index
    output var  logic                        index_out_n,   // Phase C inverted
    output var  logic                        intReq         // Level interrupt
);
    import edpo_pkg::*;

    typedef struct packed {
        logic             reverseSel;
        logic             passSel;
        logic [CNT_W-1:0] pulsesPend;
        logic [CNT_W-1:0] pulsesAct;
        logic             reverseAct;
        edpo_mode_t       mode;
        logic [POS_W-1:0] prevPos;
        logic             primed;
        logic [POS_W-1:0] acc;
        logic             step;
        logic             stepFwd;
        logic             idxReq;
        logic             setErr;
        logic             overSpd;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqEn;
        logic [DATA_W-1:0] rdata;
        logic             pA;
        logic             pAn;
        logic             pB;
        logic             pBn;
        logic             pC;
        logic             pCn;
        logic             irq;
    } edpo_state_t;

    edpo_state_t      st_r;
    edpo_state_t      st_nxt;
    logic [POS_W-1:0] delta;
    logic             deltaFwd;
    logic             deltaRev;
    logic [18:0]      inc;
    logic [19:0]      accT;
    logic [15:0]      ceilNow;
    logic             restartWr;
    logic             overNow;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;
    logic             aA;
    logic             aB;
    logic             aC;

    edpo_quad_if qif ();

    edpo_quad_gen edpo_quad_gen_i (
        .clk     (clk),
        .reset_n (reset_n),
        .q       (qif.gen)
    );

    assign qif.step   = st_r.step;
    assign qif.fwd    = st_r.stepFwd;
    assign qif.idxReq = st_r.idxReq;

    always_comb begin
        st_nxt    = st_r;
        delta     = encPos - st_r.prevPos;
        deltaFwd  = encValid && st_r.primed && (delta == 18'h00001);
        deltaRev  = encValid && st_r.primed && (delta == 18'h3FFFF);
        inc       = {st_r.pulsesAct[16:0], 2'b00};
        accT      = {2'b00, st_r.acc};
        ceilNow   = edpo_speed_ceil(st_r.pulsesAct);
        restartWr = regWr && (regAddr == REG_RESTART) && regWdata[RESTART_BIT];
        irqSet    = '0;
        irqClr    = '0;
        aA        = 1'b0;
        aB        = 1'b0;
        aC        = 1'b0;

        // Register writes
        if (regWr) begin
            if (regAddr == REG_CTRL) begin
                st_nxt.reverseSel = regWdata[CTRL_REV_BIT];
                st_nxt.passSel    = regWdata[CTRL_PASS_BIT];
            end else if (regAddr == REG_PULSES) begin
                st_nxt.pulsesPend = regWdata[CNT_W-1:0];
            end else if (regAddr == REG_IRQ_EN) begin
                st_nxt.irqEn = regWdata[IRQ_W-1:0];
            end else if (regAddr == REG_IRQ_CLR) begin
                irqClr = regWdata[IRQ_W-1:0];
            end
        end

        // Settings move to the active copy only on restart
        if (restartWr) begin
            st_nxt.pulsesAct  = st_r.pulsesPend; // R4
            st_nxt.reverseAct = st_r.reverseSel; // R4
            st_nxt.acc        = '0;
            st_nxt.primed     = 1'b0;
            if (st_r.passSel) begin
                st_nxt.mode   = MODE_PASS; // R2
                st_nxt.setErr = 1'b0;
            end else if (edpo_count_ok(st_r.pulsesPend)) begin
                st_nxt.mode   = MODE_DIVIDE; // R3
                st_nxt.setErr = 1'b0;
            end else begin
                st_nxt.mode   = MODE_FAULT; // R9
                st_nxt.setErr = 1'b1; // R9
                irqSet[IRQ_SETERR] = 1'b1;
            end
        end

        // Divider: 4N quadrature edges per ENC_COUNTS encoder counts
        st_nxt.step   = 1'b0;
        st_nxt.idxReq = 1'b0;
        if (encValid) begin
            st_nxt.prevPos = encPos;
            st_nxt.primed  = !restartWr;
        end
        if (st_r.mode == MODE_DIVIDE && !restartWr && (deltaFwd || deltaRev)) begin
            if (deltaFwd) begin
                accT = {2'b00, st_r.acc} + {1'b0, inc}; // R3
                if (accT >= ENC_COUNTS) begin
                    accT        = accT - ENC_COUNTS;
                    st_nxt.step = 1'b1;
                end
            end else begin
                accT = {2'b00, st_r.acc} - {1'b0, inc}; // R3
                if (accT[19]) begin
                    accT        = accT + ENC_COUNTS;
                    st_nxt.step = 1'b1;
                end
            end
            st_nxt.acc = accT[POS_W-1:0];
            // Reverse setting flips the motor sense so the emitted form is unchanged
            st_nxt.stepFwd = deltaFwd ^ st_r.reverseAct; // R7 R14
            st_nxt.idxReq  = (deltaFwd && encPos == '0) ||
                             (deltaRev && st_r.prevPos == '0); // R5
            irqSet[IRQ_INDEX] = st_nxt.idxReq;
        end

        // Speed ceiling follows the count band; at most one edge per sample caps rate
        overNow        = (st_r.mode == MODE_DIVIDE) && (motorSpeed > ceilNow); // R10
        st_nxt.overSpd = overNow; // R11
        if (overNow && !st_r.overSpd) begin
            irqSet[IRQ_OVERSPD] = 1'b1;
        end

        // Sticky status: a set in the clear cycle wins
        st_nxt.irqStat = (st_r.irqStat & ~irqClr) | irqSet;
        st_nxt.irq     = |(st_nxt.irqStat & st_nxt.irqEn);

        // Output pins
        if (st_r.mode == MODE_PASS) begin
            aA = encA; // R2
            aB = encB;
            aC = encC;
        end else if (st_r.mode == MODE_DIVIDE) begin
            aA = qif.phA; // R1
            aB = qif.phB;
            aC = qif.phC; // R5
        end
        st_nxt.pA  = aA;
        st_nxt.pAn = ~aA; // R13
        st_nxt.pB  = aB;
        st_nxt.pBn = ~aB; // R13
        st_nxt.pC  = aC;
        st_nxt.pCn = ~aC; // R13

        // Read data only in the cycle after the strobe
        st_nxt.rdata = '0;
        if (regRd) begin
            if (regAddr == REG_CTRL) begin
                st_nxt.rdata[CTRL_REV_BIT]  = st_r.reverseSel;
                st_nxt.rdata[CTRL_PASS_BIT] = st_r.passSel;
            end else if (regAddr == REG_PULSES) begin
                st_nxt.rdata = {1'b0, st_r.pulsesPend};
            end else if (regAddr == REG_STATUS) begin
                st_nxt.rdata[3:0] = {st_r.reverseAct, (st_r.mode == MODE_PASS),
                                     st_r.overSpd, st_r.setErr};
            end else if (regAddr == REG_ACTIVE) begin
                st_nxt.rdata = {1'b0, st_r.pulsesAct};
            end else if (regAddr == REG_IRQ_STAT) begin
                st_nxt.rdata[IRQ_W-1:0] = st_r.irqStat;
            end else if (regAddr == REG_IRQ_EN) begin
                st_nxt.rdata[IRQ_W-1:0] = st_r.irqEn;
            end else if (regAddr == REG_SPD_CEIL) begin
                st_nxt.rdata[SPD_W-1:0] = ceilNow;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r            <= '0;
            st_r.pulsesPend <= PULSES_RESET;
            st_r.pulsesAct  <= PULSES_RESET;
            st_r.mode       <= MODE_DIVIDE;
            st_r.pAn        <= 1'b1;
            st_r.pBn        <= 1'b1;
            st_r.pCn        <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdata     = st_r.rdata;
    assign quad_out_a   = st_r.pA;
    assign quad_out_a_n = st_r.pAn;
    assign quad_out_b   = st_r.pB;
    assign quad_out_b_n = st_r.pBn;
    assign index_out    = st_r.pC;
    assign index_out_n  = st_r.pCn;
    assign intReq       = st_r.irq;

    a_pair_ab: assert property (@(posedge clk) disable iff (!reset_n)
        (quad_out_a_n == !quad_out_a) && (quad_out_b_n == !quad_out_b)) // R13
        else $error("A or B pair not complementary");
    a_pair_c: assert property (@(posedge clk) disable iff (!reset_n)
        index_out_n == !index_out) // R13
        else $error("index pair not complementary");
    a_pass_follow: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.mode == MODE_PASS) |=> (quad_out_a == $past(encA)) &&
            (quad_out_b == $past(encB)) && (index_out == $past(encC))) // R2
        else $error("pass-through lost encoder pulses");
    a_hold_count: assert property (@(posedge clk) disable iff (!reset_n)
        !restartWr |=> $stable(st_r.pulsesAct)) // R4
        else $error("active count changed without restart");
    a_apply_count: assert property (@(posedge clk) disable iff (!reset_n)
        restartWr |=> st_r.pulsesAct == $past(st_r.pulsesPend)) // R4
        else $error("restart did not apply the count");
    a_set_err: assert property (@(posedge clk) disable iff (!reset_n)
        (restartWr && !st_r.passSel && !edpo_count_ok(st_r.pulsesPend))
            |=> st_r.setErr && st_r.irqStat[IRQ_SETERR]) // R9
        else $error("bad count raised no setting alarm");
    a_full_rate: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.mode == MODE_DIVIDE && !restartWr && deltaFwd &&
            st_r.pulsesAct == BAND_X4_MAX) |=> st_r.step) // R3
        else $error("maximum count missed an edge");
    a_dir_sense: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.mode == MODE_DIVIDE && !restartWr && deltaFwd && st_r.reverseAct)
            |=> (!st_r.step || !st_r.stepFwd)) // R7
        else $error("reverse setting did not flip the sense");
    a_overspeed: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.mode == MODE_DIVIDE && motorSpeed > edpo_speed_ceil(st_r.pulsesAct))
            |=> st_r.overSpd) // R11
        else $error("overspeed not flagged");
    a_index_gated: assert property (@(posedge clk) disable iff (!reset_n)
        (st_r.mode != MODE_DIVIDE) |-> !st_r.step && !st_r.idxReq) // R5
        else $error("divider stepped outside divide mode");

    c_pass_mode: cover property (@(posedge clk) disable iff (!reset_n)
        st_r.mode == MODE_PASS);
    c_set_err: cover property (@(posedge clk) disable iff (!reset_n) $rose(st_r.setErr));
    c_overspeed: cover property (@(posedge clk) disable iff (!reset_n) $rose(st_r.overSpd));
    c_index_out: cover property (@(posedge clk) disable iff (!reset_n) $rose(index_out));
endmodule
`default_nettype wire

// >>> tb/edpo_host_model.sv
// Host side model: decodes the quadrature pairs and index pulse of the divider.
// Assumes outputs that change only just after rising clock edges.
`default_nettype none
module edpo_host_model (
    input  wire logic clk,     // System clock
    input  wire logic reset_n, // Async reset, active low
    input  wire logic qa,      // Phase A
    input  wire logic qan,     // Phase A inverted
    input  wire logic qb,      // Phase B
    input  wire logic qbn,     // Phase B inverted
    input  wire logic qc,      // Index
    input  wire logic qcn,     // Index inverted
    output var  int   count,   // Signed position count
    output var  int   idxCnt,  // Index pulses seen
    output var  int   errCnt,  // Pair or step faults
    output var  int   aWidth,  // Last phase A high width
    output var  int   cWidth   // Last index high width
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph;
    logic [1:0] phOld;
    logic [1:0] d;
    logic       aOld;
    logic       cOld;
    int         aRun;
    int         cRun;
    assign ph = {qb, qa ^ qb};
    assign d  = ph - phOld;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count  <= 0;
            idxCnt <= 0;
            errCnt <= 0;
            aWidth <= 0;
            cWidth <= 0;
            aRun   <= 0;
            cRun   <= 0;
            phOld  <= 2'h0;
            aOld   <= 1'b0;
            cOld   <= 1'b0;
        end else begin
            phOld <= ph;
            aOld  <= qa;
            cOld  <= qc;
            aRun  <= qa ? aRun + 1 : 0;
            cRun  <= qc ? cRun + 1 : 0;
            // Skipped quadrature state counts as a fault
            case (d)
                2'h1: count <= count + 1;
                2'h3: count <= count - 1;
                2'h2: errCnt <= errCnt + 1;
                default: ;
            endcase
            if (qa == qan || qb == qbn || qc == qcn) begin
                errCnt <= errCnt + 1;
            end
            // Index only counted; no origin return is made
            if (qc && !cOld) begin
                idxCnt <= idxCnt + 1;
            end
            if (!qa && aOld) begin
                aWidth <= aRun;
            end
            if (!qc && cOld) begin
                cWidth <= cRun;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/encoder_pulse_divider_output_test.sv
// Testbench for the divided pulse output: register port, encoder stimulus, host model.
// Assumes the register map and latencies of the divider's hand-over.
`default_nettype none
module encoder_pulse_divider_output_test;
    timeunit 1ns;
    timeprecision 1ps;
    import edpo_pkg::*;
    localparam logic [31:0] TN [10] = '{32'h10, 32'hF, 32'h1800, 32'h2000, 32'h4000,
        32'h4001, 32'h41C4, 32'h61A9, 32'h8004, 32'h10004};
    localparam logic [31:0] TC [10] = '{32'h3E80, 32'h0, 32'h3E80, 32'h2EE0, 32'h1770,
        32'h0, 32'h0BB8, 32'h0, 32'h05DC, 32'h0};
    localparam logic [9:0]  TE = 10'h2A2;
    logic clk;
    logic reset_n;
    logic regWr;
    logic regRd;
    logic encValid;
    logic encA;
    logic encB;
    logic encC;
    logic qa;
    logic qan;
    logic qb;
    logic qbn;
    logic qc;
    logic qcn;
    logic intReq;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata;
    logic [DATA_W-1:0] regRdata;
    logic [POS_W-1:0]  encPos;
    logic [POS_W-1:0]  pos;
    logic [SPD_W-1:0]  motorSpeed;
    int count;
    int idxCnt;
    int errCnt;
    int aWidth;
    int cWidth;
    int base;
    int n_fail;
    int tests_run;
    edpo_divider edpo_divider_i (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .encPos(encPos), .encValid(encValid), .encA(encA), .encB(encB), .encC(encC),
        .motorSpeed(motorSpeed), .quad_out_a(qa), .quad_out_a_n(qan), .quad_out_b(qb),
        .quad_out_b_n(qbn), .index_out(qc), .index_out_n(qcn), .intReq(intReq));
    edpo_host_model edpo_host_model_i (.clk(clk), .reset_n(reset_n), .qa(qa), .qan(qan),
        .qb(qb), .qbn(qbn), .qc(qc), .qcn(qcn), .count(count), .idxCnt(idxCnt),
        .errCnt(errCnt), .aWidth(aWidth), .cWidth(cWidth));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim;
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(nm, exp, regRdata);
    endtask
    task automatic rs(input logic [31:0] ctrl, input logic [31:0] n);
        wr(REG_CTRL, ctrl);
        wr(REG_PULSES, n);
        wr(REG_RESTART, 32'h1);
    endtask
    task automatic move(input int n, input logic [17:0] dir);
        repeat (n) begin
            pos = pos + dir;
            @(posedge clk);
            encValid <= 1'b1;
            encPos   <= pos;
            @(posedge clk);
            encValid <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic waitChkIrq(input logic exp);
        repeat (3) @(posedge clk);
        #1 chk("intReq", {31'h0, exp}, {31'h0, intReq});
    endtask
    initial begin
        {regWr, regRd, encValid, encA, encB, encC} = 6'h00;
        reset_n = 1'b0;
        regAddr = '0;
        regWdata = '0;
        encPos = '0;
        motorSpeed = '0;
        n_fail = 0;
        tests_run = 0;
        pos = 18'h3FF00;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rdc("pulses", REG_PULSES, 32'h200);
        rdc("active", REG_ACTIVE, 32'h200);
        rdc("status", REG_STATUS, 32'h0);
        rdc("unmapped", 8'h24, 32'h0);
        wr(REG_ACTIVE, 32'h5);
        wr(REG_PULSES, 32'h10000);
        rdc("active", REG_ACTIVE, 32'h200);
        wr(REG_RESTART, 32'h1);
        rdc("active", REG_ACTIVE, 32'h10000);
        // Start below the wrap so one revolution boundary is crossed each way
        move(512, 18'h00001);
        chk("count", 32'd511, 32'(count));
        chk("index", 32'd1, 32'(idxCnt));
        chk("aWidth", 32'd4, 32'(aWidth));
        chk("cWidth", 32'd4, 32'(cWidth));
        rdc("irqStat", REG_IRQ_STAT, 32'h4);
        move(512, 18'h3FFFF);
        chk("count", 32'hFFFFFFFF, 32'(count));
        chk("index", 32'd2, 32'(idxCnt));
        wr(REG_IRQ_CLR, 32'h7);
        motorSpeed <= 16'd1500;
        repeat (2) @(posedge clk);
        rdc("status", REG_STATUS, 32'h0);
        @(posedge clk);
        motorSpeed <= 16'd1501;
        repeat (2) @(posedge clk);
        rdc("status", REG_STATUS, 32'h2);
        rdc("irqStat", REG_IRQ_STAT, 32'h2);
        waitChkIrq(1'b0);
        wr(REG_IRQ_EN, 32'h2);
        rdc("irqEn", REG_IRQ_EN, 32'h2);
        waitChkIrq(1'b1);
        @(posedge clk);
        motorSpeed <= 16'd0;
        wr(REG_IRQ_CLR, 32'h2);
        waitChkIrq(1'b0);
        base = count;
        rs(32'h1, 32'h10000);
        rdc("ctrl", REG_CTRL, 32'h1);
        rdc("status", REG_STATUS, 32'h8);
        move(100, 18'h00001);
        chk("revCount", 32'd99, 32'(base - count));
        rs(32'h2, 32'h10);
        rdc("status", REG_STATUS, 32'h4);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            // Gray order keeps the host decoder free of skipped states
            {encA, encB, encC} <= 3'(i ^ (i >> 1));
            @(posedge clk);
            #1 chk("pass", {29'h0, 3'(i ^ (i >> 1))}, {29'h0, qa, qb, qc});
        end
        @(posedge clk);
        {encA, encB, encC} <= 3'h0;
        for (int i = 0; i < 10; i++) begin
            rs(32'h0, TN[i]);
            rdc("setErr", REG_STATUS, {31'h0, TE[i]});
            if (TC[i] != 32'h0) begin
                rdc("ceil", REG_SPD_CEIL, TC[i]);
            end
        end
        rdc("irqStat", REG_IRQ_STAT, 32'h1);
        chk("pairErr", 32'h0, 32'(errCnt));
        end_sim();
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
